// file: cbci_bus_control.sv
`timescale 1ns/1ps

// Summary of operation
// R01: reset clears program counter to zero
// R02: reset clears interrupt enable and grant
// R03: reset leaves working data untouched
// R04: far side holds reset three clocks
// R05: bus released only after cycle completes
// R06: hold seen when halted or ready
// R07: hold floats address, data; grant shown
// R08: grant at third state or after
// R09: grant first, buses float one edge later; for reads two edges later (write data floats on the grant edge)
// R10: interrupt taken at instruction end, halt
// R11: no interrupt in hold or disabled
// R12: enable, disable ops drive enable output
// R13: accepted interrupt clears enable in fetch
// R14: enable effective after following instruction
// R15: input strobe marks data bus input
// R16: write strobe low with data valid
// R17: cycle-start strobe at every cycle
// R18: status word on data bus then
// R19: wait states while ready is low
// R20: wait output high in wait states
// R21: sixteen address bits, io port duplicated
module cbci_bus_control (
   // clock and reset
   input  wire logic                 clock,
   input  wire logic                 reset,
   // core cycle requests
   input  wire logic                 req_valid,
   input  wire cbci_pkg::cbci_cycle_e req_kind,
   input  wire logic                 req_from_pc,
   input  wire logic [15:0]          req_addr,
   input  wire logic [7:0]           req_wdata,
   input  wire logic                 req_last,
   output logic                      req_taken,
   output logic                      rsp_valid,
   output logic [7:0]                rsp_rdata,
   // core control
   input  wire logic                 pc_load,
   input  wire logic [15:0]          pc_value,
   input  wire logic                 enable_interrupts_op,
   input  wire logic                 disable_interrupts_op,
   input  wire logic                 halt_op,
   output logic                      int_ack,
   // system pins
   input  wire logic                 hold_req,
   input  wire logic                 int_req,
   input  wire logic                 ready,
   output logic                      bus_grant_ack,
   output logic                      interrupt_enable_out,
   output logic                      wait_out,
   // bus strobes
   output logic                      sync,
   output logic                      data_input_strobe,
   output logic                      write_n,
   // address and data pins
   output logic [15:0]               addr_out,
   output logic                      addr_oe,
   input  wire logic [7:0]           data_in,
   output logic [7:0]                data_out,
   output logic                      data_oe
);

   // ********************
   // declarations
   // ********************
   cbci_pkg::cbci_state_e state;
   cbci_pkg::cbci_state_e next_state;
   cbci_pkg::cbci_state_e resume_state;
   cbci_pkg::cbci_cycle_e cur_kind;
   logic [15:0]           pc;
   logic [15:0]           next_addr;
   logic [7:0]            cur_wdata;
   logic                  cur_write;
   logic                  cur_last;
   logic                  halt_pend;
   logic                  inta_pending;
   logic                  take;
   logic                  inst_end;
   logic                  in_xfer;
   logic                  hold_seen;
   logic                  grant_read;
   logic                  grant_write;
   logic                  accept;

   // ********************
   // helpers
   // ********************
   // status word for the cycle about to begin
   function automatic logic [7:0] status_of(cbci_pkg::cbci_cycle_e k, logic inta);
      logic [7:0] s;
      s = 8'h00;
      case (k)
         cbci_pkg::CYC_FETCH: begin
            s[cbci_pkg::ST_FETCH] = 1'b1;
            s[cbci_pkg::ST_WO_N] = 1'b1;
            s[cbci_pkg::ST_INTA] = inta;
            s[cbci_pkg::ST_MEMR] = !inta;
         end
         cbci_pkg::CYC_MREAD: begin
            s[cbci_pkg::ST_MEMR] = 1'b1;
            s[cbci_pkg::ST_WO_N] = 1'b1;
         end
         cbci_pkg::CYC_SREAD: begin
            s[cbci_pkg::ST_MEMR]  = 1'b1;
            s[cbci_pkg::ST_STACK] = 1'b1;
            s[cbci_pkg::ST_WO_N]  = 1'b1;
         end
         cbci_pkg::CYC_SWRITE: begin
            s[cbci_pkg::ST_STACK] = 1'b1;
         end
         cbci_pkg::CYC_IN: begin
            s[cbci_pkg::ST_INP]  = 1'b1;
            s[cbci_pkg::ST_WO_N] = 1'b1;
         end
         cbci_pkg::CYC_OUT: begin
            s[cbci_pkg::ST_OUT] = 1'b1;
         end
         default: begin
            s = 8'h00;
         end
      endcase
      return s;
   endfunction

   // writes drive the data bus; everything else reads it
   function automatic logic is_write(cbci_pkg::cbci_cycle_e k);
      return (k == cbci_pkg::CYC_MWRITE) || (k == cbci_pkg::CYC_SWRITE)
             || (k == cbci_pkg::CYC_OUT);
   endfunction

   // ********************
   // sequencer
   // ********************
   // in the transfer slots the ready input is sampled
   assign in_xfer = (state == cbci_pkg::ST_SECOND_STATE)
                    || (state == cbci_pkg::ST_WAIT_STATE_SLOT);

   // for reads, hold is noticed only in a transfer slot with ready high
   assign hold_seen = in_xfer && ready && hold_req;          // [R06]

   // where the bus goes once no cycle is running
   always_comb begin
      if (halt_pend) begin
         resume_state = cbci_pkg::ST_HALT;
      end else if (req_valid) begin
         resume_state = cbci_pkg::ST_FIRST_STATE;
      end else begin
         resume_state = cbci_pkg::ST_IDLE;
      end
   end

   // next state; hold waits for the running cycle to finish
   always_comb begin
      next_state = state;
      case (state)
         cbci_pkg::ST_IDLE: begin
            next_state = resume_state;
         end
         cbci_pkg::ST_FIRST_STATE: begin
            next_state = cbci_pkg::ST_SECOND_STATE;
         end
         cbci_pkg::ST_SECOND_STATE, cbci_pkg::ST_WAIT_STATE_SLOT: begin
            if (ready) begin
               next_state = cbci_pkg::ST_THIRD_STATE;
            end else begin
               next_state = cbci_pkg::ST_WAIT_STATE_SLOT;  // [R19]
            end
         end
         cbci_pkg::ST_THIRD_STATE: begin
            if (bus_grant_ack || (cur_write && hold_req)) begin
               next_state = cbci_pkg::ST_HOLD;             // [R05]
            end else begin
               next_state = resume_state;
            end
         end
         cbci_pkg::ST_HOLD: begin
            if (!hold_req) begin
               next_state = resume_state;
            end
         end
         cbci_pkg::ST_HALT: begin
            if (hold_req) begin
               next_state = cbci_pkg::ST_HOLD;             // [R06]
            end else if (!halt_pend) begin
               next_state = cbci_pkg::ST_IDLE;
            end
         end
         default: begin
            next_state = cbci_pkg::ST_IDLE;
         end
      endcase
   end

   // state register
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         state <= cbci_pkg::ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // a request is taken on the edge that starts its first state
   assign take = req_valid && (next_state == cbci_pkg::ST_FIRST_STATE);
   assign inst_end = (state == cbci_pkg::ST_THIRD_STATE) && cur_last;

   // grant for reads comes with the third state; writes one later
   assign grant_read  = hold_seen && !cur_write;             // [R08]
   assign grant_write = (state == cbci_pkg::ST_THIRD_STATE) && cur_write
                        && hold_req;                         // [R08]

   // ********************
   // cycle bookkeeping
   // ********************
   // cycle kind and end-of-instruction mark, latched at take
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         cur_kind  <= cbci_pkg::CYC_FETCH;
         cur_write <= 1'b0;
         cur_last  <= 1'b0;
      end else if (take) begin
         cur_kind  <= req_kind;
         cur_write <= is_write(req_kind);
         cur_last  <= req_last;
      end
   end

   // write data is plain datapath: no reset, so reset leaves it alone
   always_ff @(posedge clock) begin
      if (take) begin
         cur_wdata <= req_wdata;                             // [R03]
      end
   end

   // acknowledge of a taken request, one cycle
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         req_taken <= 1'b0;
      end else begin
         req_taken <= take;
      end
   end

   // program counter; an acknowledge fetch does not advance it
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         pc <= cbci_pkg::PC_RESET;                           // [R01]
      end else if (pc_load) begin
         pc <= pc_value;
      end else if (take && req_from_pc && !inta_pending) begin
         pc <= pc + 16'h0001;
      end
   end

   // io port number appears on both address halves
   always_comb begin
      if (req_kind == cbci_pkg::CYC_IN || req_kind == cbci_pkg::CYC_OUT) begin
         next_addr = {req_addr[7:0], req_addr[7:0]};         // [R21]
      end else if (req_from_pc) begin
         next_addr = pc;                                     // [R01]
      end else begin
         next_addr = req_addr;                               // [R21]
      end
   end

   // halt stays pending until an interrupt is accepted
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         halt_pend <= 1'b0;
      end else if (halt_op) begin
         halt_pend <= 1'b1;
      end else if (accept) begin
         halt_pend <= 1'b0;
      end
   end

   // marks the next fetch as an interrupt acknowledge; set wins
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         inta_pending <= 1'b0;
      end else if (accept) begin
         inta_pending <= 1'b1;
      end else if (take && req_kind == cbci_pkg::CYC_FETCH) begin
         inta_pending <= 1'b0;
      end
   end

   // ********************
   // interrupt enable
   // ********************
   cbci_int_enable u_int_enable (
      .clock                 (clock),
      .reset                 (reset),
      .enable_interrupts_op  (enable_interrupts_op),
      .disable_interrupts_op (disable_interrupts_op),
      .inst_end              (inst_end),
      .halted                (state == cbci_pkg::ST_HALT),
      .in_hold               (bus_grant_ack),                 // [R11]
      .busy                  (inta_pending),
      .clear_on_fetch        (take && inta_pending
                              && req_kind == cbci_pkg::CYC_FETCH), // [R13]
      .int_req               (int_req),
      .int_en                (interrupt_enable_out),          // [R12]
      .accept                (accept)
   );

   assign int_ack = accept;

   // ********************
   // pin outputs
   // ********************
   // grant rises before the address floats (write data floats on the same edge), falls on leaving hold
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         bus_grant_ack <= 1'b0;                              // [R02]
      end else if (grant_read || grant_write) begin
         bus_grant_ack <= 1'b1;                              // [R08] [R09]
      end else if (state == cbci_pkg::ST_HALT && hold_req) begin
         bus_grant_ack <= 1'b1;                              // [R07]
      end else if (next_state != cbci_pkg::ST_HOLD) begin
         bus_grant_ack <= 1'b0;
      end
   end

   // address floats from the second edge of hold, one after grant for writes and halt, two after for reads
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         addr_oe <= 1'b1;
      end else begin
         addr_oe <= !(state == cbci_pkg::ST_HOLD
                      && next_state == cbci_pkg::ST_HOLD);   // [R07] [R09]
      end
   end

   // address changes only when a new cycle starts
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         addr_out <= cbci_pkg::PC_RESET;
      end else if (take) begin
         addr_out <= next_addr;
      end
   end

   // cycle-start strobe covers exactly the first state
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         sync <= 1'b0;
      end else begin
         sync <= (next_state == cbci_pkg::ST_FIRST_STATE);   // [R17]
      end
   end

   // status in the first state, write data through the write cycle
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         data_out <= cbci_pkg::DATA_RESET;
      end else if (take) begin
         data_out <= status_of(req_kind, inta_pending);      // [R18]
      end else if (state == cbci_pkg::ST_FIRST_STATE) begin
         data_out <= cur_wdata;                              // [R16]
      end
   end

   // data is driven for status and for writes, never in hold
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         data_oe <= 1'b0;
      end else begin
         data_oe <= (next_state == cbci_pkg::ST_FIRST_STATE)  // [R18]
                    || (cur_write && (next_state == cbci_pkg::ST_SECOND_STATE
                    || next_state == cbci_pkg::ST_WAIT_STATE_SLOT
                    || next_state == cbci_pkg::ST_THIRD_STATE)); // [R16]
      end
   end

   // write strobe low only in the third state, inside data_oe
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         write_n <= 1'b1;
      end else begin
         write_n <= !(cur_write
                      && next_state == cbci_pkg::ST_THIRD_STATE); // [R16]
      end
   end

   // input strobe across the read transfer slots
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         data_input_strobe <= 1'b0;
      end else begin
         data_input_strobe <= !cur_write
                              && (next_state == cbci_pkg::ST_SECOND_STATE
                              || next_state == cbci_pkg::ST_WAIT_STATE_SLOT
                              || next_state == cbci_pkg::ST_THIRD_STATE); // [R15]
      end
   end

   // wait flag through every wait slot and while halted
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         wait_out <= 1'b0;
      end else begin
         wait_out <= (next_state == cbci_pkg::ST_WAIT_STATE_SLOT) // [R20]
                     || (next_state == cbci_pkg::ST_HALT);
      end
   end

   // read data captured at the end of the third state
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         rsp_valid <= 1'b0;
         rsp_rdata <= cbci_pkg::DATA_RESET;
      end else begin
         rsp_valid <= (state == cbci_pkg::ST_THIRD_STATE) && !cur_write; // [R19]
         if (state == cbci_pkg::ST_THIRD_STATE && !cur_write) begin
            rsp_rdata <= data_in;                            // [R15]
         end
      end
   end

endmodule

// file: cbci_int_enable.sv
`timescale 1ns/1ps

// interrupt enable flip-flop, enable delay and acceptance
module cbci_int_enable (
   // clock and reset
   input  wire logic clock,
   input  wire logic reset,
   // core instruction events
   input  wire logic enable_interrupts_op,
   input  wire logic disable_interrupts_op,
   input  wire logic inst_end,
   input  wire logic halted,
   input  wire logic in_hold,
   input  wire logic busy,
   input  wire logic clear_on_fetch,
   // request and results
   input  wire logic int_req,
   output logic      int_en,
   output logic      accept
);

   logic en_mask;

   // enable flop: cleared by reset, disable op and ack fetch
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         int_en <= 1'b0;                              // [R02]
      end else if (disable_interrupts_op || clear_on_fetch) begin
         int_en <= 1'b0;                              // [R12] [R13]
      end else if (enable_interrupts_op) begin
         int_en <= 1'b1;                              // [R12]
      end
   end

   // masks the enabling instruction's own end
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         en_mask <= 1'b0;
      end else if (enable_interrupts_op) begin
         en_mask <= !inst_end;                        // [R14]
      end else if (inst_end) begin
         en_mask <= 1'b0;                             // [R14]
      end
   end

   // accept pulse; its own pulse blocks a double accept
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         accept <= 1'b0;
      end else begin
         accept <= int_req && int_en && !en_mask && !in_hold && !busy && !accept
                   && (inst_end || halted);           // [R10] [R11] [R14]
      end
   end

endmodule

// file: cbci_mem_model.sv
`timescale 1ns/1ps

// ********************
// memory and port model on the far side of the bus
// ********************
module cbci_mem_model (
   // clock and reset
   input  wire logic        clock,
   input  wire logic        reset,
   // wait states asked for on the next cycle
   input  wire logic [3:0]  waits,
   // bus pins
   input  wire logic        sync,
   input  wire logic        data_input_strobe,
   input  wire logic        write_n,
   input  wire logic [15:0] addr_out,
   input  wire logic [7:0]  data_out,
   output logic      [7:0]  data_in,
   output logic             ready
);
   logic [7:0] mem [16];
   logic [7:0] last;
   logic [3:0] left;

   initial begin
      for (int i = 0; i < 16; i++) begin
         mem[i] = 8'(i * 17);
      end
      last = 8'h00;
   end

   // countdown from cycle start holds ready low
   always @(posedge clock or posedge reset) begin
      if (reset) begin
         left <= 4'h0;
      end else if (sync) begin
         left <= waits;
      end else if (left != 4'h0) begin
         left <= left - 4'h1;
      end
   end
   assign ready = (left == 4'h0);

   // memory and ports share one array
   always @(posedge clock) begin
      if (!write_n) begin
         mem[addr_out[3:0]] <= data_out;
      end
      if (data_input_strobe) begin
         last <= data_in;
      end
   end

   // ungated bus shows the inverse of its last value
   assign data_in = data_input_strobe ? mem[addr_out[3:0]] : ~last;
endmodule

// file: cbci_monitor.sv
`timescale 1ns/1ps

// ********************
// protocol checker on the bus-control pins
// ********************
module cbci_monitor (
   // clock and reset
   input wire logic       clock,
   input wire logic       reset,
   // core events
   input wire logic       enable_interrupts_op,
   input wire logic       disable_interrupts_op,
   input wire logic       int_ack,
   // system pins
   input wire logic       hold_req,
   input wire logic       int_req,
   input wire logic       ready,
   input wire logic       bus_grant_ack,
   input wire logic       interrupt_enable_out,
   input wire logic       wait_out,
   // bus pins
   input wire logic       sync,
   input wire logic       data_input_strobe,
   input wire logic       write_n,
   input wire logic       addr_oe,
   input wire logic [7:0] data_out,
   input wire logic       data_oe
);
   default clocking mon_cb @(posedge clock); endclocking
   default disable iff (reset);

   // status and write data must own the bus while shown
   AST_STATUS_DRIVEN: assert property (sync |-> data_oe && !data_input_strobe)
      else $error("status word not driven at cycle start");
   AST_SYNC_PULSE: assert property (sync |=> !sync)
      else $error("cycle start longer than one state");
   AST_WRITE_DRIVES: assert property (!write_n |-> data_oe && !data_input_strobe)
      else $error("write strobe without driven data");
   AST_WRITE_HELD: assert property ($fell(write_n) |-> $stable(data_out))
      else $error("write data moved as strobe fell");
   AST_INPUT_FLOATS: assert property (data_input_strobe |-> !data_oe)
      else $error("input strobe while data driven");
   // wait state lasts while ready stays low
   AST_WAIT_HOLDS: assert property (wait_out && !ready && !hold_req && !int_req |=> wait_out)
      else $error("wait ended with ready low");
   // grant needs a request and comes before the float
   AST_GRANT_CAUSE: assert property ($rose(bus_grant_ack) |-> $past(hold_req))
      else $error("grant without hold request");
   AST_GRANT_FIRST: assert property ($rose(bus_grant_ack) |-> addr_oe)
      else $error("address floated before grant");
   AST_FLOAT_IN_HOLD: assert property (bus_grant_ack [*3] |-> !addr_oe && !data_oe)
      else $error("buses driven in hold");
   AST_DI_CLEARS: assert property (disable_interrupts_op && !enable_interrupts_op
      |=> !interrupt_enable_out)
      else $error("disable op left enable set");
   AST_ACK_CAUSE: assert property (int_ack |->
      $past(int_req) && $past(interrupt_enable_out) && !$past(bus_grant_ack))
      else $error("interrupt taken while disabled or held");
endmodule

bind cbci_bus_control cbci_monitor u_monitor (.*);

// file: cbci_pkg.sv
package cbci_pkg;

   // ********************
   // widths and reset values
   // ********************
   localparam int          ADDR_W     = 16;
   localparam int          DATA_W     = 8;
   localparam int          PORT_W     = 8;
   localparam logic [15:0] PC_RESET   = 16'h0000;
   localparam logic [7:0]  DATA_RESET = 8'h00;
   // least reset length the far side must give, in clocks
   localparam int          RESET_MIN_CLOCKS = 3;

   // ********************
   // status word bit positions
   // ********************
   localparam int ST_INTA  = 0;
   localparam int ST_WO_N  = 1;
   localparam int ST_STACK = 2;
   localparam int ST_HLTA  = 3;
   localparam int ST_OUT   = 4;
   localparam int ST_FETCH = 5;
   localparam int ST_INP   = 6;
   localparam int ST_MEMR  = 7;

   // ********************
   // machine cycle kinds asked for by the core
   // ********************
   typedef enum logic [2:0] {
      CYC_FETCH  = 3'h0,
      CYC_MREAD  = 3'h1,
      CYC_MWRITE = 3'h2,
      CYC_SREAD  = 3'h3,
      CYC_SWRITE = 3'h4,
      CYC_IN     = 3'h5,
      CYC_OUT    = 3'h6
   } cbci_cycle_e;

   // ********************
   // bus sequencer states, one-hot
   // ********************
   typedef enum logic [6:0] {
      ST_IDLE              = 7'h01,
      ST_FIRST_STATE       = 7'h02,
      ST_SECOND_STATE      = 7'h04,
      ST_WAIT_STATE_SLOT   = 7'h08,
      ST_THIRD_STATE       = 7'h10,
      ST_HOLD              = 7'h20,
      ST_HALT              = 7'h40
   } cbci_state_e;

endpackage

// file: test_cpu_bus_control_interface.sv
`timescale 1ns/1ps

// ********************
// self-checking bench for the bus control block
// ********************
module test_cpu_bus_control_interface;
   logic                  clock, reset, req_valid, req_from_pc, req_last, pc_load;
   logic                  enable_interrupts_op, disable_interrupts_op, halt_op;
   logic                  hold_req, int_req, ready, req_taken, rsp_valid, int_ack;
   logic                  bus_grant_ack, interrupt_enable_out, wait_out, sync;
   logic                  data_input_strobe, write_n, addr_oe, data_oe;
   logic [15:0]           req_addr, pc_value, addr_out;
   logic [7:0]            req_wdata, rsp_rdata, data_in, data_out;
   logic [3:0]            waits;
   cbci_pkg::cbci_cycle_e req_kind;
   int                    fail_count, total_checks, acks;

   cbci_bus_control dut (.*);
   cbci_mem_model far_end (.*);

   initial begin
      clock = 0;
      forever #25 clock = ~clock;
   end

   // accepted interrupts, counted on the pulse
   always @(posedge clock) begin
      if (int_ack === 1'b1) acks++;
   end

   task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
         fail_count++;
      end
   endtask

   task automatic pulse(ref logic s);
      @(negedge clock);
      s = 1;
      @(negedge clock);
      s = 0;
   endtask

   // one machine cycle; d is write data or expected read data, st the status word
   task automatic cyc(input logic [2:0] k, input logic [15:0] a, input logic [7:0] d,
                      input logic ls, input logic [3:0] w, input logic [7:0] st);
      int   nw;
      logic done;
      nw = 0;
      done = 0;
      waits = w;
      @(negedge clock);
      req_valid = 1;
      req_kind = cbci_pkg::cbci_cycle_e'(k);
      req_addr = req_from_pc ? ~a : a;
      req_wdata = d;
      req_last = ls;
      repeat (40) begin
         @(negedge clock);
         if (sync) begin
            chk("status", data_out, st);
            chk("address", addr_out, (k > 4) ? {a[7:0], a[7:0]} : a);
         end
         if (req_taken) req_valid = 0;
         if (wait_out) nw++;
         if (!write_n) begin
            chk("wdata", data_out, d);
            done = 1;
         end
         if (rsp_valid) begin
            chk("rdata", rsp_rdata, d);
            done = 1;
         end
         if (done) break;
      end
      chk("done", done, 1);
      chk("waits", nw, w);
   endtask

   task automatic t_reset;
      chk("addr", addr_out, 0);
      chk("interrupt_enable_out", interrupt_enable_out, 0);
      chk("grant", bus_grant_ack, 0);
      chk("wr", write_n, 1);
      reset = 0;
      req_from_pc = 1;
      cyc(0, 16'h0000, 8'h00, 0, 0, 8'ha2);
      pc_value = 16'h000e;
      pulse(pc_load);
      cyc(0, 16'h000e, 8'hee, 0, 0, 8'ha2);
      req_from_pc = 0;
      $display("t_reset done");
   endtask

   task automatic t_kinds;
      cyc(2, 16'h1233, 8'h5a, 0, 0, 8'h00);
      cyc(1, 16'h1233, 8'h5a, 0, 0, 8'h82);
      cyc(4, 16'hfff4, 8'ha5, 0, 0, 8'h04);
      cyc(3, 16'hfff4, 8'ha5, 0, 0, 8'h86);
      cyc(6, 16'h0007, 8'h3c, 0, 0, 8'h10);
      cyc(5, 16'h0007, 8'h3c, 0, 0, 8'h42);
      cyc(1, 16'h0005, 8'h55, 0, 3, 8'h82);
      $display("t_kinds done");
   endtask

   task automatic t_hold;
      hold_req = 1;
      cyc(1, 16'h0002, 8'h22, 0, 0, 8'h82);
      chk("grant rd", bus_grant_ack, 1);
      repeat (2) @(negedge clock);
      chk("float a", addr_oe, 0);
      chk("float d", data_oe, 0);
      hold_req = 0;
      @(negedge clock);
      chk("release", bus_grant_ack, 0);
      chk("drive a", addr_oe, 1);
      hold_req = 1;
      cyc(2, 16'h0009, 8'h99, 0, 0, 8'h00);
      chk("no grant 3rd", bus_grant_ack, 0);
      @(negedge clock);
      chk("grant wr", bus_grant_ack, 1);
      hold_req = 0;
      @(negedge clock);
      chk("release wr", bus_grant_ack, 0);
      $display("t_hold done");
   endtask

   task automatic t_int;
      int_req = 1;
      pulse(enable_interrupts_op);
      chk("ie on", interrupt_enable_out, 1);
      acks = 0;
      cyc(0, 16'h000c, 8'hcc, 1, 0, 8'ha2);
      repeat (2) @(negedge clock);
      chk("early", acks, 0);
      cyc(0, 16'h0006, 8'h66, 1, 0, 8'ha2);
      repeat (2) @(negedge clock);
      chk("accept", acks, 1);
      cyc(0, 16'h0008, 8'h88, 0, 0, 8'h23);
      chk("ie off", interrupt_enable_out, 0);
      cyc(0, 16'h000a, 8'haa, 1, 0, 8'ha2);
      repeat (2) @(negedge clock);
      chk("ignored", acks, 1);
      int_req = 0;
      pulse(enable_interrupts_op);
      pulse(disable_interrupts_op);
      chk("dis", interrupt_enable_out, 0);
      pulse(enable_interrupts_op);
      reset = 1;
      repeat (4) @(negedge clock);
      reset = 0;
      chk("rst ie", interrupt_enable_out, 0);
      $display("t_int done");
   endtask

   task automatic t_halt;
      pulse(halt_op);
      @(negedge clock);
      chk("halt wait", wait_out, 1);
      hold_req = 1;
      repeat (2) @(negedge clock);
      chk("halt grant", bus_grant_ack, 1);
      hold_req = 0;
      @(negedge clock);
      chk("halt release", bus_grant_ack, 0);
      $display("t_halt done");
   endtask

   task automatic wrap_up;
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   // reset is held four clocks, past the three the far side owes
   initial begin
      {req_valid, req_from_pc, req_last, pc_load, halt_op, hold_req, int_req} = '0;
      {enable_interrupts_op, disable_interrupts_op} = '0;
      req_kind = cbci_pkg::CYC_FETCH;
      req_addr = 16'h0000;
      req_wdata = 8'h00;
      pc_value = 16'h0000;
      waits = 4'h0;
      fail_count = 0;
      total_checks = 0;
      acks = 0;
      reset = 1;
      repeat (4) @(negedge clock);
      t_reset;
      t_kinds;
      t_hold;
      t_int;
      t_halt;
      wrap_up;
   end

   // run is well under two hundred clocks; cut a hang short
   initial begin
      #100000;
      fail_count++;
      wrap_up;
   end
endmodule
